// File: verilog/mssup_pkg.sv
package mssup_pkg;
  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned AVG_WINDOW_MS = 300;
  localparam int unsigned OVC_QUAL_MS = 1500;
  localparam int unsigned PWM_OFF_WAIT_MS = 300;
  localparam int unsigned CHECK_MS = 1000;
  localparam int unsigned RETRY_OFF_MS = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned AVG_WINDOW_CYC = AVG_WINDOW_MS * CYC_PER_MS;
  // windows of the averager needed to cover each interval
  localparam int unsigned OVC_QUAL_WIN = OVC_QUAL_MS / AVG_WINDOW_MS;
  localparam int unsigned PWM_OFF_WAIT_WIN = PWM_OFF_WAIT_MS / AVG_WINDOW_MS;
  localparam int unsigned CHECK_WIN = (CHECK_MS + AVG_WINDOW_MS - 1) / AVG_WINDOW_MS;
  localparam int unsigned RETRY_OFF_WIN = (RETRY_OFF_MS + AVG_WINDOW_MS - 1) / AVG_WINDOW_MS;
  // ==========================================================
  // current scaling
  // ==========================================================
  localparam int unsigned ADC_W = 12;
  localparam int unsigned MA_W = 16;
  // sense codes are 1 mV per lsb; switch side 1 V/A gives 1 mA per lsb
  localparam int unsigned SW_MV_PER_A = 1000;
  localparam int unsigned DRV_MV_PER_A = 1100;
  localparam logic [MA_W-1:0] STALL_LIMIT_MA = 16'h02BC; // 700 mA
  localparam logic [MA_W-1:0] MATCH_TOL_MA = 16'h0064;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned WIN_CNT_W = 32;
  localparam int unsigned SEQ_CNT_W = 4;
  // ==========================================================
  // states
  // ==========================================================
  typedef enum logic [2:0] {
    MSSUP_ST_POWER_UP = 3'b000,
    MSSUP_ST_CHECK    = 3'b001,
    MSSUP_ST_RUN      = 3'b010,
    MSSUP_ST_PWM_OFF  = 3'b011,
    MSSUP_ST_RETRY    = 3'b100,
    MSSUP_ST_HALT     = 3'b101
  } mssup_state_e;
endpackage : mssup_pkg

// File: verilog/mssup_avg.sv
`timescale 1ns/1ps
// window averager: sums samples over a fixed window, outputs sum/count
module mssup_avg
  import mssup_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // sample in
  input wire logic [ADC_W-1:0] sample_i,
  // window length in clock cycles
  input wire logic [WIN_CNT_W-1:0] win_cyc_i,
  // average out
  output logic [ADC_W-1:0] avg_o,
  output logic done_o
);
  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [WIN_CNT_W-1:0] cnt;
    logic [47:0] acc;
    logic [ADC_W-1:0] avg;
    logic done;
  } mssup_avg_s;
  mssup_avg_s st_r;
  mssup_avg_s st_nxt;
  logic [47:0] quot;
  // divide at window end only; the window length is a constant so the
  // divider collapses to a constant divide in synthesis
  assign quot = st_r.acc / {16'h0000, win_cyc_i};
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (st_r.cnt == win_cyc_i - 32'h00000001)
    begin
      st_nxt.cnt = '0;
      st_nxt.acc = {36'h000000000, sample_i};
      st_nxt.avg = quot[ADC_W-1:0];
      st_nxt.done = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h00000001;
      st_nxt.acc = st_r.acc + {36'h000000000, sample_i};
    end
  end
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign avg_o = st_r.avg;
  assign done_o = st_r.done;
endmodule : mssup_avg

// File: verilog/mssup_top.sv
`timescale 1ns/1ps
module mssup_top
  import mssup_pkg::*;
#(
  parameter logic [WIN_CNT_W-1:0] AVG_CYC = AVG_WINDOW_CYC,
  parameter logic [MA_W-1:0] TOL_MA = MATCH_TOL_MA
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // host side
  input wire logic start_i,
  input wire logic [DUTY_W-1:0] pwm_duty_i,
  input wire logic duty_scale_en_i,
  // current senses, 1 mV per lsb
  input wire logic [ADC_W-1:0] switch_current_sense_i,
  input wire logic [ADC_W-1:0] driver_current_sense_i,
  // drive outputs
  output logic driver_supply_enable_o,
  output logic pwm_enable_o,
  output logic user_alarm_o,
  output logic [2:0] state_o
);
  // ==========================================================
  // input synchronisers (three stages, second and third agree)
  // ==========================================================
  typedef struct packed {
    logic [2:0] start_sy;
    logic start_q;
    logic [2:0][ADC_W-1:0] sw_sy;
    logic [2:0][ADC_W-1:0] drv_sy;
    logic [ADC_W-1:0] sw_q;
    logic [ADC_W-1:0] drv_q;
    mssup_state_e state;
    logic [SEQ_CNT_W-1:0] win_cnt;
    logic [MA_W+3:0] sw_sum;
    logic [MA_W+3:0] drv_sum;
    logic supply_en;
    logic pwm_en;
    logic alarm;
  } mssup_top_s;
  mssup_top_s st_r;
  mssup_top_s st_nxt;
  logic [ADC_W-1:0] sw_avg;
  logic [ADC_W-1:0] drv_avg;
  logic sw_done;
  logic drv_done;
  logic [MA_W-1:0] sw_ma;
  logic [MA_W-1:0] drv_ma;
  logic [MA_W-1:0] drv_cmp_ma;
  logic [31:0] drv_prod;
  logic [31:0] duty_prod;
  logic over_lim;
  logic [MA_W+3:0] diff;
  // ==========================================================
  // averagers
  // ==========================================================
  mssup_avg u_avg_sw (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .sample_i(st_r.sw_q),
    .win_cyc_i(AVG_CYC),
    .avg_o(sw_avg),
    .done_o(sw_done)
  );
  mssup_avg u_avg_drv (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .sample_i(st_r.drv_q),
    .win_cyc_i(AVG_CYC),
    .avg_o(drv_avg),
    .done_o(drv_done)
  );
  // ==========================================================
  // scaling to mA
  // ==========================================================
  assign sw_ma = MA_W'({4'h0, sw_avg} * SW_MV_PER_A / SW_MV_PER_A);
  assign drv_prod = {20'h00000, drv_avg} * 32'h000003E8 / DRV_MV_PER_A;
  assign drv_ma = drv_prod[MA_W-1:0];
  // duty scaling only feeds the check comparison, never the overcurrent decision
  assign duty_prod = {16'h0000, drv_ma} * {24'h000000, pwm_duty_i} / 32'h000000FF;
  assign drv_cmp_ma = duty_scale_en_i ? duty_prod[MA_W-1:0] : drv_ma;
  // overcurrent is judged on raw driver current, not duty level
  assign over_lim = drv_ma > STALL_LIMIT_MA;
  assign diff = (st_r.sw_sum > st_r.drv_sum) ? st_r.sw_sum - st_r.drv_sum
                                             : st_r.drv_sum - st_r.sw_sum;
  // ==========================================================
  // supervisor sequence
  // ==========================================================
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.start_sy = {st_r.start_sy[1:0], start_i};
    st_nxt.sw_sy = {st_r.sw_sy[1:0], switch_current_sense_i};
    st_nxt.drv_sy = {st_r.drv_sy[1:0], driver_current_sense_i};
    if (st_r.start_sy[2] == st_r.start_sy[1])
      st_nxt.start_q = st_r.start_sy[2];
    if (st_r.sw_sy[2] == st_r.sw_sy[1])
      st_nxt.sw_q = st_r.sw_sy[2];
    if (st_r.drv_sy[2] == st_r.drv_sy[1])
      st_nxt.drv_q = st_r.drv_sy[2];
    unique case (st_r.state)
      MSSUP_ST_POWER_UP:
      begin
        if (st_r.start_q)
        begin
          st_nxt.supply_en = 1'b1;
          st_nxt.win_cnt = '0;
          st_nxt.sw_sum = '0;
          st_nxt.drv_sum = '0;
          st_nxt.state = MSSUP_ST_CHECK;
        end
      end
      MSSUP_ST_CHECK:
      begin
        // sample PWM during the check; a partial first window hits both paths alike
        st_nxt.pwm_en = 1'b1;
        if (sw_done)
        begin
          st_nxt.sw_sum = st_r.sw_sum + {4'h0, sw_ma};
          st_nxt.drv_sum = st_r.drv_sum + {4'h0, drv_cmp_ma};
          st_nxt.win_cnt = st_r.win_cnt + 4'h1;
          if (st_r.win_cnt == SEQ_CNT_W'(CHECK_WIN))
          begin
            if (diff <= {4'h0, TOL_MA} * (MA_W + 4)'(CHECK_WIN))
            begin
              st_nxt.win_cnt = '0;
              st_nxt.state = MSSUP_ST_RUN;
            end
            else
            begin
              st_nxt.supply_en = 1'b0;
              st_nxt.pwm_en = 1'b0;
              st_nxt.alarm = 1'b1;
              st_nxt.state = MSSUP_ST_HALT;
            end
          end
        end
      end
      MSSUP_ST_RUN:
      begin
        st_nxt.pwm_en = 1'b1;
        if (drv_done)
        begin
          if (!over_lim)
            st_nxt.win_cnt = '0;
          else if (st_r.win_cnt == SEQ_CNT_W'(OVC_QUAL_WIN - 1))
          begin
            st_nxt.pwm_en = 1'b0;
            st_nxt.win_cnt = '0;
            st_nxt.state = MSSUP_ST_PWM_OFF;
          end
          else
            st_nxt.win_cnt = st_r.win_cnt + 4'h1;
        end
      end
      MSSUP_ST_PWM_OFF:
      begin
        st_nxt.pwm_en = 1'b0;
        if (drv_done)
        begin
          if (!over_lim)
          begin
            st_nxt.win_cnt = '0;
            st_nxt.state = MSSUP_ST_RETRY;
          end
          else if (st_r.win_cnt == SEQ_CNT_W'(PWM_OFF_WAIT_WIN - 1))
          begin
            st_nxt.supply_en = 1'b0;
            st_nxt.alarm = 1'b1;
            st_nxt.state = MSSUP_ST_HALT;
          end
          else
            st_nxt.win_cnt = st_r.win_cnt + 4'h1;
        end
      end
      MSSUP_ST_RETRY:
      begin
        if (drv_done)
        begin
          st_nxt.win_cnt = st_r.win_cnt + 4'h1;
          if (st_r.win_cnt == SEQ_CNT_W'(RETRY_OFF_WIN - 1))
          begin
            st_nxt.win_cnt = '0;
            st_nxt.state = MSSUP_ST_RUN;
          end
        end
      end
      MSSUP_ST_HALT:
      begin
        // permanent: only a reset leaves this state
        st_nxt.supply_en = 1'b0;
        st_nxt.pwm_en = 1'b0;
        st_nxt.alarm = 1'b1;
      end
      default:
        st_nxt.state = MSSUP_ST_HALT;
    endcase
  end
  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign driver_supply_enable_o = st_r.supply_en;
  assign pwm_enable_o = st_r.pwm_en;
  assign user_alarm_o = st_r.alarm;
  assign state_o = st_r.state;
endmodule : mssup_top

// File: verif/mssup_chk.sv
`timescale 1ns/1ps
// ==========
// port checker for the stall supervisor
module mssup_chk
  import mssup_pkg::*;
#(
  parameter logic [WIN_CNT_W-1:0] AVG_CYC = AVG_WINDOW_CYC
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // watched outputs
  input wire logic driver_supply_enable_o,
  input wire logic pwm_enable_o,
  input wire logic user_alarm_o,
  input wire logic [2:0] state_o
);
  localparam int OFF_MAX = 2 * AVG_CYC + 4;
  localparam int RUN_MIN = 4 * AVG_CYC;
  logic [15:0] run_cnt_r;
  logic [15:0] run_cnt_nxt;
  // run time since entry; window alignment may eat almost one window
  always_comb run_cnt_nxt = (state_o == MSSUP_ST_RUN) ? run_cnt_r + 16'h0001 : 16'h0000;
  // counter register
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i) run_cnt_r <= 16'h0000;
    else run_cnt_r <= run_cnt_nxt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_off_entry;
    state_o == MSSUP_ST_PWM_OFF && $past(state_o) == MSSUP_ST_RUN;
  endsequence
  sequence s_off_exit;
    ##[1:OFF_MAX] (state_o == MSSUP_ST_RETRY || state_o == MSSUP_ST_HALT);
  endsequence
  property p_pwm_needs_supply;
    pwm_enable_o |-> driver_supply_enable_o;
  endproperty
  property p_run_entry;
    state_o == MSSUP_ST_RUN && $past(state_o) != MSSUP_ST_RUN
      |-> $past(state_o) == MSSUP_ST_CHECK || $past(state_o) == MSSUP_ST_RETRY;
  endproperty
  property p_halt_outputs;
    state_o == MSSUP_ST_HALT |-> !driver_supply_enable_o && !pwm_enable_o && user_alarm_o;
  endproperty
  property p_halt_stays;
    state_o == MSSUP_ST_HALT |=> state_o == MSSUP_ST_HALT;
  endproperty
  property p_off_no_pwm;
    state_o == MSSUP_ST_PWM_OFF |-> !pwm_enable_o;
  endproperty
  property p_qual_time;
    s_off_entry |-> int'(run_cnt_r) >= RUN_MIN;
  endproperty
  property p_off_bound;
    s_off_entry |-> s_off_exit;
  endproperty
  property p_retry_outputs;
    state_o == MSSUP_ST_RETRY |-> !pwm_enable_o && driver_supply_enable_o;
  endproperty
  property p_idle_quiet;
    state_o == MSSUP_ST_POWER_UP |-> !pwm_enable_o && !user_alarm_o;
  endproperty
  a_pwm_needs_supply: assert property (p_pwm_needs_supply) else $error("pwm without supply");
  a_run_entry: assert property (p_run_entry) else $error("run entered illegally");
  a_halt_outputs: assert property (p_halt_outputs) else $error("halt outputs wrong");
  a_halt_stays: assert property (p_halt_stays) else $error("halt left");
  a_off_no_pwm: assert property (p_off_no_pwm) else $error("pwm on in pwm_off");
  a_qual_time: assert property (p_qual_time) else $error("overcurrent too early");
  a_off_bound: assert property (p_off_bound) else $error("pwm_off too long");
  a_retry_outputs: assert property (p_retry_outputs) else $error("retry outputs wrong");
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle outputs wrong");
endmodule : mssup_chk

// File: verif/mssup_plant.sv
`timescale 1ns/1ps
// ==========
// load switch, motor driver and both current senses
module mssup_plant
  import mssup_pkg::*;
(
  // drive from supervisor
  input wire logic supply_en_i,
  input wire logic pwm_en_i,
  // bench controls
  input wire logic [15:0] load_ma_i,
  input wire logic pwm_stuck_i,
  input wire logic signed [15:0] err_ma_i,
  // sense outputs
  output logic [ADC_W-1:0] sw_sense_o,
  output logic [ADC_W-1:0] drv_sense_o
);
  int flow_ma;
  int drv_ma;
  // current flows only with supply and drive; a stuck line keeps drive on
  always_comb
  begin
    flow_ma = (supply_en_i && (pwm_en_i || pwm_stuck_i)) ? int'(load_ma_i) : 0;
    drv_ma = (flow_ma == 0) ? 0 : flow_ma + int'(err_ma_i);
    if (drv_ma < 0) drv_ma = 0;
    sw_sense_o = ADC_W'(flow_ma);
    drv_sense_o = ADC_W'(drv_ma * 11 / 10);
  end
endmodule : mssup_plant

// File: verif/testbench.sv
`timescale 1ns/1ps
// ==========
// supervisor testbench
module testbench;
  import mssup_pkg::*;
  localparam logic [WIN_CNT_W-1:0] AVG = 'h14;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic sup_en, pwm_en, alarm;
  logic [2:0] state;
  logic [ADC_W-1:0] sw_sense, drv_sense;
  logic [15:0] load_ma = 16'h012C;
  logic signed [15:0] err_ma = 16'sh0000;
  logic stuck = 1'b0;
  logic [DUTY_W-1:0] duty = 8'h80;
  logic duty_en = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  // duty only scales the check reading; it does not steer the overcurrent transitions
  mssup_top #(.AVG_CYC(AVG)) DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(start_i),
    .pwm_duty_i(duty), .duty_scale_en_i(duty_en), .switch_current_sense_i(sw_sense),
    .driver_current_sense_i(drv_sense), .driver_supply_enable_o(sup_en),
    .pwm_enable_o(pwm_en), .user_alarm_o(alarm), .state_o(state));
  mssup_plant u_plant (.supply_en_i(sup_en), .pwm_en_i(pwm_en), .load_ma_i(load_ma),
    .pwm_stuck_i(stuck), .err_ma_i(err_ma), .sw_sense_o(sw_sense), .drv_sense_o(drv_sense));
  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wait_st(input logic [2:0] st, input int max);
    for (int i = 0; i < max && state !== st; i++) @(posedge mclk_i) #1;
    chk(state, st);
  endtask : wait_st
  // reset, then raise start with a chosen driver sense error
  task t_start(input logic signed [15:0] err);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    start_i <= 1'b0;
    err_ma <= err;
    load_ma <= 16'h012C;
    stuck <= 1'b0;
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1 chk({sup_en, pwm_en, alarm, state}, 0);
    @(posedge mclk_i) start_i <= 1'b1;
    for (int i = 0; i < 10 && sup_en !== 1'b1; i++) @(posedge mclk_i) #1;
    chk(sup_en, 1);
    chk(pwm_en, 0);
  endtask : t_start
  task t_run;
    t_start(16'sh0032);
    wait_st(MSSUP_ST_RUN, 200);
    chk(alarm, 0);
    $display("test run done");
  endtask : t_run
  task t_stall;
    @(posedge mclk_i) load_ma <= 16'h028A;
    repeat (200) @(posedge mclk_i);
    #1 chk(state, MSSUP_ST_RUN);
    @(posedge mclk_i) load_ma <= 16'h0320;
    // qualification may run up to one window short of five windows, never more
    repeat (4 * AVG) @(posedge mclk_i);
    #1 chk(state, MSSUP_ST_RUN);
    wait_st(MSSUP_ST_PWM_OFF, 200);
    chk(pwm_en, 0);
    wait_st(MSSUP_ST_RETRY, 60);
    @(posedge mclk_i) load_ma <= 16'h012C;
    wait_st(MSSUP_ST_RUN, 150);
    chk(sup_en, 1);
    $display("test stall retry done");
  endtask : t_stall
  task t_bad;
    t_start(-16'sh012C);
    wait_st(MSSUP_ST_HALT, 200);
    chk({sup_en, pwm_en, alarm}, 3'h1);
    $display("test sense mismatch done");
  endtask : t_bad
  task t_stuck;
    t_start(16'sh0000);
    wait_st(MSSUP_ST_RUN, 200);
    @(posedge mclk_i);
    stuck <= 1'b1;
    load_ma <= 16'h0320;
    wait_st(MSSUP_ST_PWM_OFF, 200);
    wait_st(MSSUP_ST_HALT, 60);
    chk({sup_en, alarm}, 2'h1);
    repeat (50) @(posedge mclk_i);
    #1 chk(state, MSSUP_ST_HALT);
    $display("test stuck drive done");
  endtask : t_stuck
  // raw driver reading doubled by back-emf; half duty scaling restores the match
  task t_scale;
    @(posedge mclk_i);
    duty_en <= 1'b1;
    duty <= 8'h80;
    t_start(16'sh012C);
    wait_st(MSSUP_ST_RUN, 200);
    chk(alarm, 0);
    @(posedge mclk_i) duty <= 8'h00;
    repeat (200) @(posedge mclk_i);
    #1 chk(state, MSSUP_ST_RUN);
    @(posedge mclk_i) duty_en <= 1'b0;
    $display("test duty scaling done");
  endtask : t_scale
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial
  begin
    t_run;
    t_stall;
    t_bad;
    t_stuck;
    t_scale;
    finish_test;
  end
  // watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    finish_test;
  end
endmodule : testbench
bind mssup_top mssup_chk #(.AVG_CYC(AVG_CYC)) u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .driver_supply_enable_o(driver_supply_enable_o), .pwm_enable_o(pwm_enable_o),
  .user_alarm_o(user_alarm_o), .state_o(state_o));
